// ---- mse_engine_status.sv ----
// Behaviour
// - equation 5: three products VA*IA, VB*IB, VC*IC, their sum, three squared currents
// - frame results IA..ID at words 0x00-0x06, temp 0x0A, battery 0x0B
// - raw placement fixed; byte address is four times word address
// - word 0x0F read-only: zero upper half, part code, revision
// - status word 0x80 refreshed at each end of pass
// - sag flags not held over passes, re-evaluated every pass
// - status bits 31:29 always read zero
// - status bit 28 square wave at fundamental of selected phase
// - sag bit sets after count low samples, clears when voltage rises
// - config word at 0x20, reset 0x5020, packed fields
// - sag enable bit per phase gates its part in the aux sag event; status sag bits ignore it
// - sag-to-pulse bit makes sag event toggle aux pulse pin
// - shunt select gives current channel gain of 8
// - pulse source 1: rates from processor watt and var words
// - pulse source 0: rates from engine total watt and var sums
// - sag enables bits 20:18; sag only when all enabled phases sag
// - sag count bits 15:8, default 80, max 255
// - phase select 00 A, 01 B, 10 C, 11 not allowed
`include "mse_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module mse_engine_status #(
  parameter logic [7:0] PART_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0] REVISION  = 8'h01   // arbitrary value
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RST_B,
  input  wire logic [11:0]        I_MEM_ADDR,
  input  wire logic               I_MEM_WR,
  input  wire logic               I_MEM_RD,
  input  wire logic [31:0]        I_MEM_WDATA,
  output var  logic [31:0]        O_MEM_RDATA,
  output var  logic               O_MEM_RVALID,
  input  wire logic               I_FRAME_END,
  input  wire mse_pkg::mse_frame_t I_FRAME,
  input  wire logic               I_VSAMP_VALID,
  input  wire mse_pkg::mse_vsamp_t I_VSAMP,
  input  wire logic               I_PASS_END,
  input  wire logic [2:0]         I_EQU_SEL,
  input  wire logic [31:0]        I_TOTAL_WATT_SUM,
  input  wire logic [31:0]        I_TOTAL_VAR_SUM,
  output var  mse_pkg::mse_trio_t O_ELEM,
  output var  logic [31:0]        O_ELEM_SUM,
  output var  mse_pkg::mse_trio_t O_ISQ_SUM,
  output var  logic               O_EQU_OK,
  output var  logic [31:0]        O_WATT_RATE,
  output var  logic [31:0]        O_VAR_RATE,
  output var  logic               O_AUX_PULSE
);

  logic [31:0]         cfg_q;
  logic [31:0]         sag_threshold_q;
  logic [31:0]         watt_rate_q;
  logic [31:0]         var_rate_q;
  logic [31:0]         status_q;
  mse_pkg::mse_frame_t raw_q;
  logic [7:0]          sag_sample_count_q [3];
  logic [2:0]          sag_live_q;
  logic [2:0]          sign_q;
  logic                f0_q;
  logic                sag_all_q;
  mse_pkg::mse_trio_t  elem_acc_q;
  mse_pkg::mse_trio_t  isq_acc_q;
  logic [31:0]         cur_a;
  logic [31:0]         cur_b;
  logic [31:0]         cur_c;
  logic [31:0]         vs [3];
  logic [2:0]          sag_en;
  logic                sag_all_d;
  logic [9:0]          word_idx;
  mse_pkg::mse_phase_t psel;

  // byte address to engine word index
  assign word_idx = I_MEM_ADDR[11:`MSE_BYTE_SHIFT];
  assign sag_en   = cfg_q[`MSE_CFG_SAG_EN_HI:`MSE_CFG_SAG_EN_LO];
  assign psel     = mse_pkg::mse_phase_t'(cfg_q[`MSE_CFG_PSEL_HI:`MSE_CFG_PSEL_LO]);
  assign vs[0]    = I_VSAMP.va;
  assign vs[1]    = I_VSAMP.vb;
  assign vs[2]    = I_VSAMP.vc;

  // two's complement magnitude, so negative half-cycles sag too
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  // signed product, upper word kept to stay in 32 bits
  function automatic logic [31:0] mul_hi(input logic [31:0] x, input logic [31:0] y);
    logic signed [63:0] p;
    p      = $signed(x) * $signed(y);
    mul_hi = p[63:32];
  endfunction

  // extra gain of 8 when shunt sensing is selected
  function automatic logic [31:0] shunt(input logic [31:0] v, input logic sel);
    shunt = sel ? (v <<< `MSE_SHUNT_SHIFT) : v;
  endfunction

  assign cur_a = shunt(raw_q.ia, cfg_q[`MSE_CFG_SHUNT_LO]);
  assign cur_b = shunt(raw_q.ib, cfg_q[`MSE_CFG_SHUNT_LO + 1]);
  assign cur_c = shunt(raw_q.ic, cfg_q[`MSE_CFG_SHUNT_HI]);

  // configuration and processor-owned words
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      cfg_q       <= `MSE_CFG_RESET;
      sag_threshold_q   <= `MSE_SAG_THRESHOLD_RESET;
      watt_rate_q <= 32'h0000_0000;
      var_rate_q  <= 32'h0000_0000;
    end
    else if (I_MEM_WR)
    begin
      if (word_idx == `MSE_IDX_CFG)
      begin
        cfg_q <= I_MEM_WDATA & `MSE_CFG_WR_MASK;
      end
      else if (word_idx == `MSE_IDX_SAG_THRESHOLD)
      begin
        sag_threshold_q <= I_MEM_WDATA;
      end
      else if (word_idx == `MSE_IDX_WATT_RATE)
      begin
        watt_rate_q <= I_MEM_WDATA;
      end
      else if (word_idx == `MSE_IDX_VAR_RATE)
      begin
        var_rate_q <= I_MEM_WDATA;
      end
    end
  end

  // raw words are hard-wired to the converter; processor writes ignored
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      raw_q <= '0;
    end
    else if (I_FRAME_END)
    begin
      raw_q <= I_FRAME;
    end
  end

  // per-phase sag counters on every voltage sample
  generate
    for (genvar p = 0; p < 3; p++)
    begin : g_sag
      always_ff @(posedge I_CLK)
      begin
        if (!I_RST_B)
        begin
          sag_sample_count_q[p]  <= 8'h00;
          sag_live_q[p] <= 1'b0;
          sign_q[p]     <= 1'b0;
        end
        else if (I_VSAMP_VALID)
        begin
          sign_q[p] <= ~vs[p][31];
          if (mag(vs[p]) < sag_threshold_q)
          begin
            // saturate so a long sag cannot wrap back to zero
            if (sag_sample_count_q[p] != 8'hFF)
            begin
              sag_sample_count_q[p] <= sag_sample_count_q[p] + 8'h01;
            end
            if (sag_sample_count_q[p] + 8'h01 >= cfg_q[`MSE_CFG_CNT_HI:`MSE_CFG_CNT_LO])
            begin
              sag_live_q[p] <= 1'b1;
            end
          end
          else
          begin
            sag_sample_count_q[p]  <= 8'h00;
            sag_live_q[p] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // code 11 is illegal; fall back to phase A rather than freeze
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      f0_q <= 1'b0;
    end
    else
    begin
      case (psel)
        mse_pkg::MSE_PH_B: f0_q <= sign_q[1];
        mse_pkg::MSE_PH_C: f0_q <= sign_q[2];
        default:           f0_q <= sign_q[0];
      endcase
    end
  end

  // status snapshot of the pass just finished
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      status_q <= 32'h0000_0000;
    end
    else if (I_PASS_END)
    begin
      status_q                                <= 32'h0000_0000;
      status_q[`MSE_ST_F0]                    <= f0_q;
      status_q[`MSE_ST_SAG_HI:`MSE_ST_SAG_LO] <= sag_live_q;
    end
  end

  // all enabled phases must be in sag, none enabled means no event
  assign sag_all_d = (sag_en != 3'b000) && ((sag_live_q & sag_en) == sag_en);

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      sag_all_q   <= 1'b0;
      O_AUX_PULSE <= 1'b0;
    end
    else
    begin
      sag_all_q <= sag_all_d;
      // toggle marks the event, so one edge per sag onset
      if (sag_all_d && !sag_all_q && cfg_q[`MSE_CFG_SAG_INT])
      begin
        O_AUX_PULSE <= ~O_AUX_PULSE;
      end
    end
  end

  // element products accumulated over a pass, published at its end
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      elem_acc_q <= '0;
      isq_acc_q  <= '0;
      O_ELEM     <= '0;
      O_ISQ_SUM  <= '0;
      O_ELEM_SUM <= 32'h0000_0000;
    end
    else if (I_PASS_END)
    begin
      O_ELEM     <= elem_acc_q;
      O_ISQ_SUM  <= isq_acc_q;
      O_ELEM_SUM <= elem_acc_q.a + elem_acc_q.b + elem_acc_q.c;
      elem_acc_q <= '0;
      isq_acc_q  <= '0;
    end
    else if (I_FRAME_END && O_EQU_OK)
    begin
      // products use the previous frame, one frame of latency
      elem_acc_q.a <= elem_acc_q.a + mul_hi(raw_q.va, cur_a);
      elem_acc_q.b <= elem_acc_q.b + mul_hi(raw_q.vb, cur_b);
      elem_acc_q.c <= elem_acc_q.c + mul_hi(raw_q.vc, cur_c);
      isq_acc_q.a  <= isq_acc_q.a + mul_hi(cur_a, cur_a);
      isq_acc_q.b  <= isq_acc_q.b + mul_hi(cur_b, cur_b);
      isq_acc_q.c  <= isq_acc_q.c + mul_hi(cur_c, cur_c);
    end
  end

  // other equations are not computed, accumulators hold until cleared at pass end
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      O_EQU_OK <= 1'b0;
    end
    else
    begin
      O_EQU_OK <= (I_EQU_SEL == `MSE_EQU_3ELEM);
    end
  end

  // pulse generator rate source
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      O_WATT_RATE <= 32'h0000_0000;
      O_VAR_RATE  <= 32'h0000_0000;
    end
    else if (cfg_q[`MSE_CFG_PULSE_SOURCE_SELECT])
    begin
      O_WATT_RATE <= watt_rate_q;
      O_VAR_RATE  <= var_rate_q;
    end
    else
    begin
      O_WATT_RATE <= I_TOTAL_WATT_SUM;
      O_VAR_RATE  <= I_TOTAL_VAR_SUM;
    end
  end

  // read port, one cycle latency, unmapped words read zero
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      O_MEM_RDATA  <= 32'h0000_0000;
      O_MEM_RVALID <= 1'b0;
    end
    else
    begin
      O_MEM_RVALID <= I_MEM_RD;
      if (!I_MEM_RD)
      begin
        O_MEM_RDATA <= 32'h0000_0000;
      end
      // words 0x07..0x09 are holes in the raw map and read zero
      else if (word_idx <= `MSE_IDX_RAW_LAST)
      begin
        O_MEM_RDATA <= raw_q[word_idx[2:0]*32 +: 32];
      end
      else if (word_idx == `MSE_IDX_TEMP)
      begin
        O_MEM_RDATA <= raw_q.temp;
      end
      else if (word_idx == `MSE_IDX_VBAT)
      begin
        O_MEM_RDATA <= raw_q.vbat;
      end
      else if (word_idx == `MSE_IDX_ID)
      begin
        O_MEM_RDATA <= {16'h0000, PART_CODE, REVISION};
      end
      else if (word_idx == `MSE_IDX_CFG)
      begin
        O_MEM_RDATA <= cfg_q;
      end
      else if (word_idx == `MSE_IDX_SAG_THRESHOLD)
      begin
        O_MEM_RDATA <= sag_threshold_q;
      end
      else if (word_idx == `MSE_IDX_WATT_RATE)
      begin
        O_MEM_RDATA <= watt_rate_q;
      end
      else if (word_idx == `MSE_IDX_VAR_RATE)
      begin
        O_MEM_RDATA <= var_rate_q;
      end
      else if (word_idx == `MSE_IDX_STATUS)
      begin
        O_MEM_RDATA <= status_q;
      end
      else
      begin
        O_MEM_RDATA <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// ---- mse_cfg.svh ----
`ifndef MSE_CFG_SVH
`define MSE_CFG_SVH

// engine word indexes; byte address is four times the index
`define MSE_IDX_IA         10'h000
`define MSE_IDX_RAW_LAST   10'h006
`define MSE_IDX_TEMP       10'h00A
`define MSE_IDX_VBAT       10'h00B
`define MSE_IDX_ID         10'h00F
`define MSE_IDX_CFG        10'h020
`define MSE_IDX_SAG_THRESHOLD    10'h024
`define MSE_IDX_WATT_RATE  10'h045
`define MSE_IDX_VAR_RATE   10'h046
`define MSE_IDX_STATUS     10'h080
`define MSE_BYTE_SHIFT     2

// configuration word fields
`define MSE_CFG_RESET      32'h0000_5020
`define MSE_CFG_WR_MASK    32'h001F_FFFF
`define MSE_CFG_SAG_EN_HI  20
`define MSE_CFG_SAG_EN_LO  18
`define MSE_CFG_SAG_INT    17
`define MSE_CFG_CNT_HI     15
`define MSE_CFG_CNT_LO     8
`define MSE_CFG_PSEL_HI    7
`define MSE_CFG_PSEL_LO    6
`define MSE_CFG_PULSE_SOURCE_SELECT  5
`define MSE_CFG_SHUNT_HI   2
`define MSE_CFG_SHUNT_LO   0

// status word fields
`define MSE_ST_F0          28
`define MSE_ST_SAG_HI      27
`define MSE_ST_SAG_LO      25

// arithmetic
`define MSE_SHUNT_SHIFT    3
`define MSE_EQU_3ELEM      3'h5
`define MSE_SAG_THRESHOLD_RESET  32'h0000_0000

`endif

// ---- mse_pkg.sv ----
package mse_pkg;

  // filtered front-end results of one multiplexer frame
  typedef struct packed {
    logic [31:0] vbat;
    logic [31:0] temp;
    logic [31:0] id;
    logic [31:0] vc;
    logic [31:0] ic;
    logic [31:0] vb;
    logic [31:0] ib;
    logic [31:0] va;
    logic [31:0] ia;
  } mse_frame_t;

  // one voltage sample per phase
  typedef struct packed {
    logic [31:0] vc;
    logic [31:0] vb;
    logic [31:0] va;
  } mse_vsamp_t;

  // per-element results, index 0 = phase A
  typedef struct packed {
    logic [31:0] c;
    logic [31:0] b;
    logic [31:0] a;
  } mse_trio_t;

  typedef enum logic [1:0] {
    MSE_PH_A   = 2'b00,
    MSE_PH_B   = 2'b01,
    MSE_PH_C   = 2'b10,
    MSE_PH_BAD = 2'b11
  } mse_phase_t;

endpackage

// ---- mse_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mse_cfg.svh"
module mse_chk (
  input wire logic               I_CLK,
  input wire logic               I_RST_B,
  input wire logic [11:0]        I_MEM_ADDR,
  input wire logic               I_MEM_WR,
  input wire logic               I_MEM_RD,
  input wire logic [31:0]        I_MEM_WDATA,
  input wire logic [31:0]        O_MEM_RDATA,
  input wire logic               O_MEM_RVALID,
  input wire logic               I_VSAMP_VALID,
  input wire logic               I_PASS_END,
  input wire logic [2:0]         I_EQU_SEL,
  input wire logic [31:0]        I_TOTAL_WATT_SUM,
  input wire logic [31:0]        I_TOTAL_VAR_SUM,
  input wire mse_pkg::mse_trio_t O_ELEM,
  input wire logic [31:0]        O_ELEM_SUM,
  input wire logic               O_EQU_OK,
  input wire logic [31:0]        O_WATT_RATE,
  input wire logic [31:0]        O_VAR_RATE,
  input wire logic               O_AUX_PULSE
);
  logic ext_q;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // copy of the pulse source bit; the rate pins are only predictable with it
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
      ext_q <= 1'h1;
    else if (I_MEM_WR && I_MEM_ADDR[11:2] == `MSE_IDX_CFG)
      ext_q <= I_MEM_WDATA[`MSE_CFG_PULSE_SOURCE_SELECT];
  end

  // read timing and fixed word contents
  rd_answer_a: assert property (I_MEM_RD |=> O_MEM_RVALID)
    else $error("read not answered");
  rd_idle_a: assert property (!I_MEM_RD |=> !O_MEM_RVALID && O_MEM_RDATA == 32'h0)
    else $error("data without read");
  id_upper_a: assert property (I_MEM_RD && I_MEM_ADDR[11:2] == `MSE_IDX_ID |=>
    O_MEM_RDATA[31:16] == 16'h0) else $error("id upper half set");
  st_unused_a: assert property (I_MEM_RD && I_MEM_ADDR[11:2] == `MSE_IDX_STATUS |=>
    O_MEM_RDATA[31:29] == 3'h0) else $error("status top bits set");
  // equation gate, published sums, internal pulse source and aux pulse
  equ_gate_a: assert property ($past(I_RST_B) |-> O_EQU_OK == ($past(I_EQU_SEL) == 3'h5))
    else $error("equation flag wrong");
  elem_total_a: assert property (O_ELEM_SUM == O_ELEM.a + O_ELEM.b + O_ELEM.c)
    else $error("element sum wrong");
  pass_hold_a: assert property (!I_PASS_END |=> $stable(O_ELEM) && $stable(O_ELEM_SUM))
    else $error("sums moved inside pass");
  rate_int_a: assert property (!ext_q |=> O_WATT_RATE == $past(I_TOTAL_WATT_SUM)
    && O_VAR_RATE == $past(I_TOTAL_VAR_SUM)) else $error("rate not from totals");
  aux_cause_a: assert property ($past(I_RST_B) && $changed(O_AUX_PULSE) |->
    $past(I_VSAMP_VALID, 2)) else $error("aux moved without sample");
endmodule

bind mse_engine_status mse_chk chk_u (.*);
`default_nettype wire

// ---- mse_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mse_cpu_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output var  logic [11:0] o_addr,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [31:0] o_wdata
);
  // idle bus at time zero
  initial
  begin
    o_addr = 12'h0;
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_wdata = 32'h0;
  end

  // one word per access; on release strobes drop and address and data go inverse so no stale value looks held
  task automatic acc(input logic [9:0] w, input logic [31:0] d, input logic wr,
                     output logic [31:0] q);
    @(negedge i_clk);
    o_addr = {w, 2'h0};
    o_wdata = d;
    o_wr = wr;
    o_rd = !wr;
    @(negedge i_clk);
    q = i_rdata;
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_addr = ~o_addr;
    o_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mse_cfg.svh"
module tb;
  logic                clk = 1'h0, rst_b = 1'h0;
  logic                fend = 1'h0, vval = 1'h0, pend = 1'h0;
  logic [2:0]          equation_select = 3'h5;
  logic [31:0]         tw = 32'h0, tv = 32'h0, d, q, rdata, esum, wrate, vrate, wdata;
  mse_pkg::mse_frame_t fr = '0;
  mse_pkg::mse_vsamp_t vs = '0;
  mse_pkg::mse_trio_t  elem, isq;
  logic [11:0]         addr;
  logic                wr, rd, rvalid, equ_ok, aux, a0;
  int                  err_count = 0, n_compared = 0;

  // part code and revision are arbitrary values
  mse_engine_status #(.PART_CODE(8'h3C), .REVISION(8'h07)) dut_u (
    .I_CLK(clk), .I_RST_B(rst_b), .I_MEM_ADDR(addr), .I_MEM_WR(wr), .I_MEM_RD(rd),
    .I_MEM_WDATA(wdata), .O_MEM_RDATA(rdata), .O_MEM_RVALID(rvalid), .I_FRAME_END(fend),
    .I_FRAME(fr), .I_VSAMP_VALID(vval), .I_VSAMP(vs), .I_PASS_END(pend), .I_EQU_SEL(equation_select),
    .I_TOTAL_WATT_SUM(tw), .I_TOTAL_VAR_SUM(tv), .O_ELEM(elem), .O_ELEM_SUM(esum),
    .O_ISQ_SUM(isq), .O_EQU_OK(equ_ok), .O_WATT_RATE(wrate), .O_VAR_RATE(vrate),
    .O_AUX_PULSE(aux));
  mse_cpu_model cpu_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata));

  // clock and free-running totals so the internal pulse source is exercised
  always #2 clk = ~clk;
  always @(negedge clk)
  begin
    tw <= $urandom;
    tv <= $urandom;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e);
    cpu_u.acc(a, 32'h0, 1'h0, q);
    chk(n, e, q);
  endtask
  task automatic wrw(input logic [9:0] a, input logic [31:0] v);
    cpu_u.acc(a, v, 1'h1, q);
  endtask
  task automatic pls(ref logic s);
    @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask
  task automatic samp(input logic [31:0] a, input logic [31:0] b);
    vs = {32'h4000_0000, b, a};
    pls(vval);
  endtask
  function automatic logic [31:0] mhi(input logic [31:0] x, input logic [31:0] y);
    logic signed [63:0] p;
    p = $signed(x) * $signed(y);
    return p[63:32];
  endfunction
  function automatic logic [31:0] stw(input logic f, input logic [2:0] g);
    return {3'h0, f, g, 25'h0};
  endfunction
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog far beyond the roughly 170 cycles the tests need
  initial
  begin
    #40000;
    err_count++;
    stop_test;
  end

  initial
  begin
    void'($urandom(82200));
    repeat (2) @(negedge clk);
    rst_b = 1'h1;
    rdc("config", `MSE_IDX_CFG, 32'h0000_5020);
    wrw(`MSE_IDX_ID, 32'hFFFF_FFFF);
    rdc("id", `MSE_IDX_ID, 32'h0000_3C07);
    rdc("unmapped", 10'h3FE, 32'h0);
    d = $urandom;
    wrw(`MSE_IDX_WATT_RATE, d);
    @(negedge clk);
    chk("watt rate", d, wrate);
    d = $urandom;
    wrw(`MSE_IDX_VAR_RATE, d);
    @(negedge clk);
    chk("var rate", d, vrate);
    d = $urandom;
    wrw(`MSE_IDX_CFG, d);
    rdc("config", `MSE_IDX_CFG, d & 32'h001F_FFFF);
    // internal source: rate pins follow the totals seen at the last edge
    wrw(`MSE_IDX_CFG, 32'h0000_5000);
    @(negedge clk);
    chk("watt total", tw, wrate);
    chk("var total", tv, vrate);
    $display("test registers done");
    for (int e = 0; e < 6; e++)
    begin
      equation_select = e[2:0];
      @(negedge clk);
      chk("equ ok", {31'h0, e == 5}, {31'h0, equ_ok});
    end
    for (int s = 0; s < 2; s++)
    begin
      wrw(`MSE_IDX_CFG, 32'h0000_5020 | 32'(s));
      for (int k = 0; k < 9; k++)
        fr[k*32 +: 32] = $urandom;
      pls(fend);
      for (int k = 0; k < 7; k++)
        rdc("raw", k[9:0], fr[k*32 +: 32]);
      rdc("temp", 10'h00A, fr.temp);
      rdc("vbat", `MSE_IDX_VBAT, fr.vbat);
      pls(pend);
      pls(fend);
      pls(pend);
      chk("elem a", mhi(fr.va, s ? fr.ia << 3 : fr.ia), elem.a);
      chk("elem b", mhi(fr.vb, fr.ib), elem.b);
      chk("elem c", mhi(fr.vc, fr.ic), elem.c);
      d = s ? fr.ia << 3 : fr.ia;
      chk("elem sum", mhi(fr.va, d) + mhi(fr.vb, fr.ib) + mhi(fr.vc, fr.ic), esum);
      chk("isq a", mhi(d, d), isq.a);
      chk("isq b", mhi(fr.ib, fr.ib), isq.b);
      chk("isq c", mhi(fr.ic, fr.ic), isq.c);
    end
    $display("test products done");
    // three low samples declare a sag; one high sample in between restarts the count
    wrw(`MSE_IDX_SAG_THRESHOLD, 32'h0000_1000);
    wrw(`MSE_IDX_CFG, 32'h0006_0320);
    a0 = aux;
    repeat (2) samp($urandom_range(32'hFFF), 32'h4000_0000);
    samp(32'h0000_2000, 32'h4000_0000);
    repeat (2) samp($urandom_range(32'hFFF), 32'h4000_0000);
    pls(pend);
    rdc("status", `MSE_IDX_STATUS, stw(1'h1, 3'h0));
    chk("aux", {31'h0, a0}, {31'h0, aux});
    samp($urandom_range(32'hFFF), 32'h4000_0000);
    pls(pend);
    rdc("status", `MSE_IDX_STATUS, stw(1'h1, 3'h1));
    chk("aux", {31'h0, ~a0}, {31'h0, aux});
    samp(32'h0000_2000, 32'h4000_0000);
    pls(pend);
    rdc("status", `MSE_IDX_STATUS, stw(1'h1, 3'h0));
    wrw(`MSE_IDX_CFG, 32'h000E_0320);
    a0 = aux;
    repeat (3) samp($urandom_range(32'hFFF), 32'h4000_0000);
    // aux moves one edge after the live flags, so let that edge pass
    @(negedge clk);
    chk("aux", {31'h0, a0}, {31'h0, aux});
    repeat (3) samp($urandom_range(32'hFFF), $urandom_range(32'hFFF));
    @(negedge clk);
    chk("aux", {31'h0, ~a0}, {31'h0, aux});
    $display("test sag done");
    for (int p = 0; p < 3; p++)
    begin
      wrw(`MSE_IDX_CFG, 32'h0000_0020 | 32'(p << 6));
      vs = {32'h4000_0000, 32'h4000_0000, 32'h4000_0000};
      vs[p*32 +: 32] = 32'hC000_0000;
      pls(vval);
      repeat (3) @(negedge clk);
      pls(pend);
      rdc("square wave", `MSE_IDX_STATUS, stw(1'h0, 3'h0));
    end
    $display("test phase select done");
    stop_test;
  end
endmodule
`default_nettype wire
